// [tb.sv]
// Testbench for the register bank, driven through the host model
`timescale 1ns/1ps
module tb;
  import tpd_pkg::*;
  // ----------------------------------------------------------------
  // Signals and far-side models
  // ----------------------------------------------------------------
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       scl, host_sda, sda_oe, sda_o, tx_push, rx_pop, evt_ack;
  wire  logic sda_line;
  tpd_cc_sw_t cc_sw;
  tpd_cfg_t   cfg;
  tpd_cmd_t   cmd;
  tpd_stat_t  stat = '0;
  logic [7:0] evt_prim = '0, evt_proto = '0, tx_data, rx_data;
  logic [7:0] tx_q [$];
  logic [7:0] rx_mem [0:3] = '{8'h5A, 8'h6B, 8'h7C, 8'h8D};
  int         rx_idx = 0, error_cnt = 0, num_checks = 0;
  logic [5:0] cmd_seen = '0;
  logic [7:0] cmd_cycles = '0;
  initial evt_ack = 1'b0;
  always #25 ref_clk = ~ref_clk;
  // Pull-up wire: either party may pull it low
  assign sda_line = host_sda & (sda_oe ? sda_o : 1'b1);
  assign rx_data = rx_mem[rx_idx[1:0]];
  // Packet FIFO stand-ins log pushes and advance on pops; commands logged
  always @(posedge ref_clk) begin
    if (tx_push === 1'b1) tx_q.push_back(tx_data);
    if (rx_pop === 1'b1) rx_idx <= rx_idx + 1;
    if (!rst && cmd !== '0) begin
      cmd_seen   <= cmd_seen | cmd;
      cmd_cycles <= cmd_cycles + 8'd1;
    end
  end
  // Version 3 is arbitrary; variant and revision keep their defaults
  tpd_regs #(.VERSION(4'h3)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .cc_sw_o(cc_sw), .cfg_o(cfg),
    .cmd_o(cmd), .stat_i(stat), .evt_prim_i(evt_prim),
    .evt_proto_i(evt_proto), .evt_ack_i(evt_ack), .tx_push_o(tx_push),
    .tx_data_o(tx_data), .rx_pop_o(rx_pop), .rx_data_i(rx_data));
  tpd_host_model host_u (
    .ref_clk(ref_clk), .scl(scl), .sda_drv(host_sda), .sda_line(sda_line));
  // ----------------------------------------------------------------
  // Comparison, verdict and scenarios
  // ----------------------------------------------------------------
  task automatic chk(input logic [103:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Whole configuration span 0x02..0x10 read back in one burst
  task automatic t_reset();
    logic [119:0] e = 120'h03_20_31_60_24_00_02_06_00_01_00_0F_00_00_00;
    host_u.rd_burst(OFF_SW0, 15);
    for (int i = 0; i < 15; i++)
      chk(host_u.rbuf[i], e[119-8*i -: 8], "reset value");
  endtask
  // A write to the identity byte must leave it untouched
  task automatic t_ident();
    host_u.wbuf[0] = 8'hFF;
    host_u.wr_burst(I2C_ADDR_DEF, OFF_ID, 1);
    host_u.rd_burst(OFF_ID, 1);
    chk(host_u.rbuf[0], 8'h30, "identity");
  endtask
  // Walking one over the switch byte, then a foreign device address
  task automatic t_switch();
    tpd_cfg_t c0;
    c0 = cfg;
    for (int i = 0; i < 8; i++) begin
      host_u.wbuf[0] = 8'h01 << i;
      host_u.wr_burst(I2C_ADDR_DEF, OFF_SW0, 1);
      chk(cc_sw, 8'h01 << i, "switch");
    end
    chk(cfg, c0, "other registers");
    host_u.wbuf[0] = 8'h3C;
    host_u.wr_burst(I2C_ADDR_DEF ^ 7'h01, OFF_SW0, 1);
    chk({host_u.addr_ok, cc_sw}, 9'h080, "foreign address");
  endtask
  // Command bits pulse once per write and read back as zero
  task automatic t_cmd();
    host_u.wbuf[0] = 8'h41;
    host_u.wbuf[1] = 8'h04;
    host_u.wr_burst(I2C_ADDR_DEF, OFF_CTRL0, 2);
    host_u.wbuf[0] = 8'h40;
    host_u.wr_burst(I2C_ADDR_DEF, OFF_CTRL3, 1);
    host_u.wbuf[0] = 8'h03;
    host_u.wr_burst(I2C_ADDR_DEF, OFF_SRST, 1);
    chk({cmd_seen, cmd_cycles}, {6'h3F, 8'd4}, "commands");
    chk({cfg.ctrl0, cfg.ctrl1, cfg.ctrl3}, 24'h0, "cmd bits");
    host_u.rd_burst(OFF_CTRL0, 2);
    chk({host_u.rbuf[0], host_u.rbuf[1]}, 16'h0, "cmd read");
  endtask
  // Burst write walks the pointer across two registers only
  task automatic t_incr();
    host_u.wbuf[0] = 8'h15;
    host_u.wbuf[1] = 8'h2A;
    host_u.wr_burst(I2C_ADDR_DEF, OFF_MEAS, 2);
    chk({cfg.sw1, cfg.measure, cfg.slice}, 24'h20152A, "burst");
  endtask
  // Three bytes each way through the window; pointer must not move
  task automatic t_fifo();
    logic [23:0] w = 24'hA1B2C3;
    for (int i = 0; i < 3; i++) host_u.wbuf[i] = w[23-8*i -: 8];
    host_u.wr_burst(I2C_ADDR_DEF, OFF_FIFO, 3);
    chk(104'(tx_q.size()), 104'd3, "push count");
    for (int i = 0; i < tx_q.size(); i++)
      chk(tx_q[i], w[23-8*i -: 8], "pushed byte");
    host_u.rd_burst(OFF_FIFO, 3);
    for (int i = 0; i < 3; i++)
      chk(host_u.rbuf[i], rx_mem[i], "popped byte");
    chk(104'(rx_idx), 104'd3, "pop count");
  endtask
  // Status read live; event bytes latch, then clear on their read
  task automatic t_events();
    logic [55:0] m = 56'h3F_3F_FF_01_FF_FF_FF;
    logic [55:0] e;
    stat = '{8'h15, 8'h2A, 8'hC3, 8'h28};
    evt_prim = 8'h81;
    evt_proto = 8'h24;
    evt_ack = 1'b1;
    host_u.tick(1);
    evt_prim = 8'h00;
    evt_proto = 8'h00;
    evt_ack = 1'b0;
    for (int k = 0; k < 2; k++) begin
      e = k ? 56'h15_2A_00_00_C3_28_00 : 56'h15_2A_24_01_C3_28_81;
      host_u.rd_burst(OFF_STA0A, 7);
      for (int i = 0; i < 7; i++)
        chk(host_u.rbuf[i] & m[55-8*i -: 8], e[55-8*i -: 8], "evt");
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #5 rst = 1'b0;
    host_u.tick(2);
    t_reset();
    t_ident();
    t_switch();
    t_incr();
    t_fifo();
    t_events();
    t_cmd();
    complete_run();
  end
  // Watchdog: the traffic above needs roughly 7800 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    complete_run();
  end
endmodule

// [tpd_host_model.sv]
// Host model: two-wire bus controller that reaches the register bank
`timescale 1ns/1ps
module tpd_host_model (
  // Clock
  input  wire logic ref_clk,
  // Bus pins, SDA released by driving 1 onto the pulled-up wire
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  // Byte buffers shared with the bench, and the address ack of the last write burst
  logic [7:0] wbuf [0:15];
  logic [7:0] rbuf [0:15];
  logic       ack_ok;
  logic       addr_ok;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    ack_ok = 1'b0;
    addr_ok = 1'b0;
  end
  // Pins move a fixed 5 ns after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  // One bit: SDA changes a cycle after SCL falls, so it never looks
  // like a start or stop; phases of four cycles beat the two minimum
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_drv = b;
    tick(3);
    scl = 1'b1;
    tick(4);
    r = sda_line;
    scl = 1'b0;
  endtask
  // Eight bits msb first, then the ninth bit (m_ack drives it low)
  task automatic byte_io(input logic [7:0] b, input logic m_ack,
                         output logic [7:0] r);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], x);
      r[i] = x;
    end
    bit_io(~m_ack, x);
    ack_ok = ~x;
  endtask
  task automatic start_c();
    tick(1);
    sda_drv = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    tick(1);
    sda_drv = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(4);
  endtask
  function automatic logic mapped(input logic [7:0] a);
    return (a >= tpd_pkg::OFF_ID && a <= tpd_pkg::OFF_CTRL4) ||
           (a >= tpd_pkg::OFF_STA0A && a <= tpd_pkg::OFF_FIFO);
  endfunction
  // Pointer byte, then n data bytes from wbuf; stops early on address nack
  task automatic wr_burst(input logic [6:0] da, input logic [7:0] a,
                          input int n);
    logic [7:0] r;
    if (!mapped(a)) return;
    start_c();
    byte_io({da, 1'b0}, 1'b0, r);
    addr_ok = ack_ok;
    if (addr_ok) begin
      byte_io(a, 1'b0, r);
      for (int i = 0; i < n; i++) byte_io(wbuf[i], 1'b0, r);
    end
    stop_c();
  endtask
  // Pointer write, repeated start, n bytes into rbuf, last one nacked
  task automatic rd_burst(input logic [7:0] a, input int n);
    logic [7:0] r;
    start_c();
    byte_io({tpd_pkg::I2C_ADDR_DEF, 1'b0}, 1'b0, r);
    byte_io(a, 1'b0, r);
    start_c();
    byte_io({tpd_pkg::I2C_ADDR_DEF, 1'b1}, 1'b0, r);
    for (int i = 0; i < n; i++) byte_io(8'hFF, i < n - 1, rbuf[i]);
    stop_c();
  endtask
endmodule

// [tpd_pkg.sv]
// Package: register map, field positions, reset values and carriers
package tpd_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ID     = 8'h01;
  localparam logic [7:0] OFF_SW0    = 8'h02;
  localparam logic [7:0] OFF_SW1    = 8'h03;
  localparam logic [7:0] OFF_MEAS   = 8'h04;
  localparam logic [7:0] OFF_SLICE  = 8'h05;
  localparam logic [7:0] OFF_CTRL0  = 8'h06;
  localparam logic [7:0] OFF_CTRL1  = 8'h07;
  localparam logic [7:0] OFF_CTRL2  = 8'h08;
  localparam logic [7:0] OFF_CTRL3  = 8'h09;
  localparam logic [7:0] OFF_PRIMARY_EVENT_MASK  = 8'h0A;
  localparam logic [7:0] OFF_POWER  = 8'h0B;
  localparam logic [7:0] OFF_SRST   = 8'h0C;
  localparam logic [7:0] OFF_OCP    = 8'h0D;
  localparam logic [7:0] OFF_MASKA  = 8'h0E;
  localparam logic [7:0] OFF_MASKB  = 8'h0F;
  localparam logic [7:0] OFF_CTRL4  = 8'h10;
  localparam logic [7:0] OFF_STA0A  = 8'h3C;
  localparam logic [7:0] OFF_STA1A  = 8'h3D;
  localparam logic [7:0] OFF_EVTA   = 8'h3E;
  localparam logic [7:0] OFF_EVTB   = 8'h3F;
  localparam logic [7:0] OFF_STA0   = 8'h40;
  localparam logic [7:0] OFF_STA1   = 8'h41;
  localparam logic [7:0] OFF_EVT    = 8'h42;
  localparam logic [7:0] OFF_FIFO   = 8'h43;
  // ----------------------------------------------------------------
  // Field positions and self-clearing command bits
  // ----------------------------------------------------------------
  localparam int POS_VERSION  = 4;
  localparam int POS_VARIANT  = 2;
  localparam int POS_REVISION = 0;
  localparam int POS_TX_FLUSH = 6;
  localparam int POS_TX_START = 0;
  localparam int POS_RX_FLUSH = 2;
  localparam int POS_HARD_RST = 6;
  localparam int POS_PD_RESET = 1;
  localparam int POS_SW_RESET = 0;
  localparam logic [6:0] I2C_ADDR_DEF = 7'h22;
  // ----------------------------------------------------------------
  // Reset values of the config block
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SW0   = 8'h03;
  localparam logic [7:0] RST_SW1   = 8'h20;
  localparam logic [7:0] RST_MEAS  = 8'h31;
  localparam logic [7:0] RST_SLICE = 8'h60;
  localparam logic [7:0] RST_CTRL0 = 8'h24;
  localparam logic [7:0] RST_CTRL2 = 8'h02;
  localparam logic [7:0] RST_CTRL3 = 8'h06;
  localparam logic [7:0] RST_POWER = 8'h01;
  localparam logic [7:0] RST_OCP   = 8'h0F;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cc2_host_pullup_on;
    logic cc1_host_pullup_on;
    logic cc2_cable_supply_switch;
    logic cc1_cable_supply_switch;
    logic cc2_measure_route;
    logic cc1_measure_route;
    logic cc2_device_pulldown;
    logic cc1_device_pulldown;
  } tpd_cc_sw_t;
  typedef struct packed {
    logic [7:0] sw1, measure, slice, ctrl0, ctrl1, ctrl2, ctrl3;
    logic [7:0] primary_event_mask, power, ocp, maska, maskb, ctrl4;
  } tpd_cfg_t;
  typedef struct packed {
    logic [7:0] sta0a, sta1a, sta0, sta1;
  } tpd_stat_t;
  typedef struct packed {
    logic tx_start, tx_flush, rx_flush, hard_reset, pd_reset, sw_reset;
  } tpd_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } tpd_state_t;
  // ----------------------------------------------------------------
  // Reset values and self-clearing masks of the config block
  // ----------------------------------------------------------------
  function automatic logic [7:0] tpd_rst_val(input logic [7:0] a);
    case (a)
      OFF_SW0:   tpd_rst_val = RST_SW0;
      OFF_SW1:   tpd_rst_val = RST_SW1;
      OFF_MEAS:  tpd_rst_val = RST_MEAS;
      OFF_SLICE: tpd_rst_val = RST_SLICE;
      OFF_CTRL0: tpd_rst_val = RST_CTRL0;
      OFF_CTRL2: tpd_rst_val = RST_CTRL2;
      OFF_CTRL3: tpd_rst_val = RST_CTRL3;
      OFF_POWER: tpd_rst_val = RST_POWER;
      OFF_OCP:   tpd_rst_val = RST_OCP;
      default:   tpd_rst_val = RST_ZERO;
    endcase
  endfunction
  function automatic logic [7:0] tpd_sc_mask(input logic [7:0] a);
    case (a)
      OFF_CTRL0: tpd_sc_mask = 8'h41;
      OFF_CTRL1: tpd_sc_mask = 8'h04;
      OFF_CTRL3: tpd_sc_mask = 8'h40;
      OFF_SRST:  tpd_sc_mask = 8'hFF;
      default:   tpd_sc_mask = 8'h00;
    endcase
  endfunction
endpackage

// [tpd_regs.sv]
// Type-C/PD port register bank behind a two-wire serial slave
`timescale 1ns/1ps
// Summary of operation
// - Window 0x43 pushes TX on write, pops RX on read, pointer held.
// - Identity is read-only: version 7:4, variant 3:2, revision 1:0.
// - Switch bits 7 and 6 apply the host pull-up on CC2 and CC1.
// - Switch bits 5 and 4 close the cable supply switch onto CC2 and CC1.
// - Switch bits 3 and 2 route the measure block to CC2 and CC1.
// - Switch bits 1 and 0 enable the device pull-down on CC2 and CC1.
module tpd_regs #(
  parameter logic [6:0] DEV_ADDR = tpd_pkg::I2C_ADDR_DEF,
  parameter logic [3:0] VERSION  = 4'h5, // Arbitrary value
  parameter logic [1:0] VARIANT  = 2'h0, // Arbitrary value
  parameter logic [1:0] REVISION = 2'h0  // Arbitrary value
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Serial bus pins
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output wire logic               sda_o,
  output wire logic               sda_oe,
  // Switch and configuration outputs
  output tpd_pkg::tpd_cc_sw_t     cc_sw_o,
  output tpd_pkg::tpd_cfg_t       cfg_o,
  output tpd_pkg::tpd_cmd_t       cmd_o,
  // Status and event inputs
  input  tpd_pkg::tpd_stat_t      stat_i,
  input  wire logic [7:0]         evt_prim_i,
  input  wire logic [7:0]         evt_proto_i,
  input  wire logic               evt_ack_i,
  // Packet FIFO side
  output wire logic               tx_push_o,
  output wire logic [7:0]         tx_data_o,
  output wire logic               rx_pop_o,
  input  wire logic [7:0]         rx_data_i
);
  import tpd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_VAL = {VERSION, VARIANT, REVISION};
  tpd_state_t  state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sr_q, sr_d, ptr_q, ptr_d, rd_v;
  logic        scl_q, sda_q, rw_q, rw_d, oe_q, oe_d, first_q, first_d;
  logic        wr_stb, rd_stb, start_c, stop_c, rise_c, fall_c;
  logic [7:0]  regs_q [2:16];
  logic [7:0]  regs_d [2:16];
  logic [7:0]  prim_q, prim_d, proto_q, proto_d;
  logic        ack_q, ack_d, push_q, push_d, pop_q, pop_d;
  logic [7:0]  txd_q, txd_d;
  tpd_cmd_t    cmd_q, cmd_d;

  // Config block decode, shared by write and read paths
  function automatic logic is_cfg(input logic [7:0] a);
    is_cfg = (a >= OFF_SW0) && (a <= OFF_CTRL4) && (a != OFF_SRST);
  endfunction

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  // Bus edges and conditions from the sampled pins
  assign start_c = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c  = scl_i & scl_q & ~sda_q & sda_i;
  assign rise_c  = scl_i & ~scl_q;
  assign fall_c  = ~scl_i & scl_q;

  // Next state of the slave; data changes only on falling clock
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sr_d    = sr_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    first_d = first_q;
    wr_stb  = 1'b0;
    rd_stb  = 1'b0;
    if (start_c) begin
      state_d = ST_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end else if (stop_c) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_WR: begin
          if (rise_c) begin
            sr_d  = {sr_q[6:0], sda_i};
            cnt_d = cnt_q + 4'h1;
          end
          if (fall_c && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            if (state_q == ST_ADDR) begin
              if (sr_q[7:1] == DEV_ADDR) begin
                rw_d    = sr_q[0];
                oe_d    = 1'b1;
                state_d = ST_ADDR_ACK;
              end else begin
                state_d = ST_IDLE;
              end
            end else begin
              oe_d    = 1'b1;
              state_d = ST_WR_ACK;
              if (first_q) begin
                ptr_d   = sr_q;
                first_d = 1'b0;
              end else begin
                wr_stb = 1'b1;
                if (ptr_q != OFF_FIFO) ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_RD_ACK: begin
          // A high level during the master's ack slot ends the read
          if (state_q == ST_RD_ACK && rise_c && sda_i) begin
            state_d = ST_IDLE;
          end else if (fall_c) begin
            if (state_q == ST_ADDR_ACK && !rw_q) begin
              oe_d    = 1'b0;
              first_d = 1'b1;
              state_d = ST_WR;
            end else begin
              rd_stb  = 1'b1;
              sr_d    = rd_v;
              oe_d    = ~rd_v[7];
              cnt_d   = 4'h1;
              state_d = ST_RD;
            end
          end
        end
        ST_WR_ACK: begin
          if (fall_c) begin
            oe_d    = 1'b0;
            state_d = ST_WR;
          end
        end
        ST_RD: begin
          if (fall_c) begin
            if (cnt_q == 4'h8) begin
              oe_d    = 1'b0;
              cnt_d   = 4'h0;
              state_d = ST_RD_ACK;
              if (ptr_q != OFF_FIFO) ptr_d = ptr_q + 8'h01;
            end else begin
              sr_d  = {sr_q[6:0], 1'b0};
              oe_d  = ~sr_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // Slave registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      sr_q    <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
      first_q <= 1'b0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sr_q    <= sr_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      first_q <= first_d;
      scl_q   <= scl_i;
      sda_q   <= sda_i;
    end
  end

  // Open-drain: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  // Read data mux; blank addresses read as zero
  always_comb begin
    rd_v = 8'h00;
    if (is_cfg(ptr_q)) rd_v = regs_q[ptr_q];
    case (ptr_q)
      // Identity is a constant, never writable
      OFF_ID:    rd_v = ID_VAL;
      OFF_STA0A: rd_v = stat_i.sta0a;
      OFF_STA1A: rd_v = stat_i.sta1a;
      OFF_EVTA:  rd_v = proto_q;
      OFF_EVTB:  rd_v = {7'h00, ack_q};
      OFF_STA0:  rd_v = stat_i.sta0;
      OFF_STA1:  rd_v = stat_i.sta1;
      OFF_EVT:   rd_v = prim_q;
      OFF_FIFO:  rd_v = rx_data_i;
      default:   ;
    endcase
  end

  // Next register values, event latches and FIFO strobes
  always_comb begin
    regs_d = regs_q;
    cmd_d  = '0;
    push_d = 1'b0;
    pop_d  = 1'b0;
    txd_d  = txd_q;
    prim_d  = ((rd_stb && ptr_q == OFF_EVT)  ? 8'h00 : prim_q)  | evt_prim_i;
    proto_d = ((rd_stb && ptr_q == OFF_EVTA) ? 8'h00 : proto_q) | evt_proto_i;
    ack_d   = ((rd_stb && ptr_q == OFF_EVTB) ? 1'b0 : ack_q)    | evt_ack_i;
    // Read of the window pops one RX byte
    if (rd_stb && ptr_q == OFF_FIFO) pop_d = 1'b1;
    if (wr_stb) begin
      if (is_cfg(ptr_q)) regs_d[ptr_q] = sr_q & ~tpd_sc_mask(ptr_q);
      // Write to the window pushes one TX byte
      if (ptr_q == OFF_FIFO) begin
        push_d = 1'b1;
        txd_d  = sr_q;
      end
      // Command bits act once and read back as zero
      if (ptr_q == OFF_CTRL0) begin
        cmd_d.tx_start = sr_q[POS_TX_START];
        cmd_d.tx_flush = sr_q[POS_TX_FLUSH];
      end
      if (ptr_q == OFF_CTRL1) cmd_d.rx_flush = sr_q[POS_RX_FLUSH];
      if (ptr_q == OFF_CTRL3) cmd_d.hard_reset = sr_q[POS_HARD_RST];
      if (ptr_q == OFF_SRST) begin
        cmd_d.pd_reset = sr_q[POS_PD_RESET];
        cmd_d.sw_reset = sr_q[POS_SW_RESET];
      end
    end
  end

  // Bank registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 2; i <= 16; i++) regs_q[i] <= tpd_rst_val(8'(i));
      prim_q  <= 8'h00;
      proto_q <= 8'h00;
      ack_q   <= 1'b0;
      cmd_q   <= '0;
      push_q  <= 1'b0;
      pop_q   <= 1'b0;
      txd_q   <= 8'h00;
    end else begin
      regs_q  <= regs_d;
      prim_q  <= prim_d;
      proto_q <= proto_d;
      ack_q   <= ack_d;
      cmd_q   <= cmd_d;
      push_q  <= push_d;
      pop_q   <= pop_d;
      txd_q   <= txd_d;
    end
  end

  // Switch bits drive the CC pins
  assign cc_sw_o   = tpd_cc_sw_t'(regs_q[OFF_SW0]);
  assign cfg_o     = {regs_q[OFF_SW1], regs_q[OFF_MEAS], regs_q[OFF_SLICE],
                      regs_q[OFF_CTRL0], regs_q[OFF_CTRL1], regs_q[OFF_CTRL2],
                      regs_q[OFF_CTRL3], regs_q[OFF_PRIMARY_EVENT_MASK], regs_q[OFF_POWER],
                      regs_q[OFF_OCP], regs_q[OFF_MASKA], regs_q[OFF_MASKB],
                      regs_q[OFF_CTRL4]};
  assign cmd_o     = cmd_q;
  assign tx_push_o = push_q;
  assign tx_data_o = txd_q;
  assign rx_pop_o  = pop_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_fifo_push_data: assert property (
    (wr_stb && ptr_q == OFF_FIFO) |=> tx_push_o && tx_data_o == $past(sr_q)
      ##1 !tx_push_o) else $error("window write did not push once");
  a_fifo_ptr_hold: assert property (
    ((wr_stb || rd_stb) && ptr_q == OFF_FIFO) |=> ptr_q == OFF_FIFO)
    else $error("pointer moved off the FIFO window");
  a_id_read_value: assert property (
    (rd_stb && ptr_q == OFF_ID) |=> sr_q == ID_VAL && state_q == ST_RD)
    else $error("identity read returned wrong value");
  a_pullup_follow: assert property (
    (wr_stb && ptr_q == OFF_SW0) |=> cc_sw_o.cc2_host_pullup_on ==
      $past(sr_q[7]) && cc_sw_o.cc1_host_pullup_on == $past(sr_q[6]))
    else $error("pull-up does not follow switch write");
  a_supply_follow: assert property (
    (wr_stb && ptr_q == OFF_SW0) |=> {cc_sw_o.cc2_cable_supply_switch,
      cc_sw_o.cc1_cable_supply_switch} == $past(sr_q[5:4]))
    else $error("cable supply switch does not follow write");
  a_measure_follow: assert property (
    (wr_stb && ptr_q == OFF_SW0) ##1 !wr_stb [*2] |->
      {cc_sw_o.cc2_measure_route, cc_sw_o.cc1_measure_route} ==
      $past(sr_q[3:2], 2)) else $error("measure route lost");
  a_pulldown_reset: assert property (
    $fell(rst) |-> cc_sw_o.cc2_device_pulldown && cc_sw_o.cc1_device_pulldown)
    else $error("pull-downs not on after reset");
  a_event_rclear: assert property (
    (rd_stb && ptr_q == OFF_EVT) |=> prim_q == $past(evt_prim_i))
    else $error("read-clear dropped or kept wrong flags");
  a_write_isolated: assert property (
    (wr_stb && ptr_q != OFF_SW0) |=> $stable(cc_sw_o))
    else $error("write touched another register");

  c_fifo_push: cover property (tx_push_o ##[1:400] tx_push_o);
  c_fifo_pop: cover property (rx_pop_o);
  c_event_clear: cover property (rd_stb && ptr_q == OFF_EVT && prim_q != 0);
  c_switch_write: cover property (wr_stb && ptr_q == OFF_SW0);
endmodule
